/* design/rst_seq_pkg.sv */
// constants, modes and carriers for the reset and start-up sequencer
package rst_seq_pkg;
   // oscillator configuration codes
   typedef enum logic [2:0] {
      low_power_crystal_mode = 3'h0,
      standard_crystal_mode = 3'h1,
      high_speed_crystal_mode = 3'h2,
      resistor_cap_osc_mode = 3'h3,
      external_clock_mode = 3'h4,
      hs_pll_mode = 3'h5,
      external_clock_io_mode = 3'h6,
      resistor_cap_io_mode = 3'h7
   } osc_mode_type;

   typedef enum logic [2:0] {
      st_por = 3'h0,
      st_power_up_delay_timer = 3'h1,
      st_ost = 3'h2,
      st_pll = 3'h3,
      st_hold = 3'h4,
      st_run = 3'h5,
      st_sleep = 3'h6
   } seq_state_type;

   // status flag carrier, one bit per software-visible flag
   typedef struct packed {
      logic reset_instruction_flag;
      logic timeout_flag;
      logic power_down_flag;
      logic power_on_flag;
      logic brown_out_flag;
      logic stack_full_flag;
      logic stack_underflow_flag;
   } status_type;

   // reset cause encoding
   typedef enum logic [3:0] {
      cause_none = 4'h0,
      cause_power_on = 4'h1,
      cause_master_clear_pin_run = 4'h2,
      cause_master_clear_pin_sleep = 4'h3,
      cause_watchdog = 4'h4,
      cause_brown_out = 4'h5,
      cause_reset_instr = 4'h6,
      cause_stack_full = 4'h7,
      cause_stack_under = 4'h8,
      cause_wdt_wake = 4'h9,
      cause_int_wake = 4'ha
   } cause_type;

   localparam int unsigned sys_clk_mhz = 200;
   localparam int unsigned power_up_delay_timer_delay_ms = 72;
   localparam int unsigned pll_lock_delay_ms = 2;
   localparam int unsigned power_up_delay_timer_cycles = power_up_delay_timer_delay_ms * 1000 * sys_clk_mhz;
   localparam int unsigned pll_cycles = pll_lock_delay_ms * 1000 * sys_clk_mhz;
   localparam int unsigned ost_count = 1024;
   localparam int unsigned master_clear_pin_filter_len = 4;
   localparam int unsigned por_pulse_len = 8;
   localparam logic [20:0] pc_reset = 21'h000000;
   localparam logic [20:0] pc_vec_high = 21'h000008;
   localparam logic [20:0] pc_vec_low = 21'h000018;
   localparam status_type status_por = 7'b1110000;
endpackage : rst_seq_pkg

/* design/reset_and_startup_sequencer.sv */
// reset and start-up sequencer: reset causes, time-outs, sleep and wake
// Summary of operation
// - sleep stops clocks, holds core at phase one
// - wake on master clear, watchdog or interrupt
// - sleep drives rc/ec oscillator output low, IO modes keep pin
// - 72 ms delay only after power-on, brown-out
// - pll mode: delay, start-up count, lock delay
// - eight distinct reset causes reported
// - reset-state registers forced by listed resets
// - watchdog wake resumes, registers unchanged
// - status flags updated per cause
// - master clear filter ignores short pulses
// - master clear pin never driven
// - internal power-on pulse on supply rise
// - delay timer on internal rc, holds reset
// - delay timer active when enable bit zero
// - 1024 oscillator input cycles after delay
// - start-up count crystal modes, power-on, wake
// - brown-out enable bit gates brown-out reset
// - brown-out recurrence restarts delay timer
// - time-outs independent of master clear pin
// - rc with timer off: no time-out
// - lock delay also after wake, oscillator switch
// - interrupt wake loads vector or continues
`timescale 1ns/100ps
module reset_and_startup_sequencer
   import rst_seq_pkg::*;
#(
   parameter int unsigned power_up_delay_timer_len = power_up_delay_timer_cycles,  // power-up delay in rc ticks
   parameter int unsigned pll_len = pll_cycles,  // lock delay in clocks
   parameter int unsigned ost_len = ost_count  // start-up count
) (
   input wire logic sys_clk_i,  // system clock
   input wire logic rstn_i,  // async reset, active low
   input wire logic supply_ok_i,  // supply above power-on level
   input wire logic brown_out_det_i,  // supply under brown-out level
   input wire logic master_clear_pin_n_i,  // external master clear, low active
   input wire logic rc_tick_i,  // internal rc oscillator tick
   input wire logic osc_in_rise_i,  // rising edge on oscillator input pin
   input wire osc_mode_type osc_mode_i,  // oscillator configuration
   input wire logic powerup_timer_enable_n_i,  // 0 enables delay timer
   input wire logic brownout_enable_bit_i,  // 1 enables brown-out reset
   input wire logic sleep_instr_i,  // halt instruction executed
   input wire logic reset_instr_i,  // reset instruction executed
   input wire logic stack_full_i,  // stack overflow reset
   input wire logic stack_underflow_i,  // stack underflow reset
   input wire logic watchdog_timeout_i,  // watchdog expired
   input wire logic int_pending_i,  // enabled interrupt pending
   input wire logic high_priority_int_enable_i,  // high priority enable
   input wire logic low_priority_int_enable_i,  // low priority enable
   input wire logic int_high_i,  // pending interrupt is high priority
   input wire logic osc_switch_i,  // switch back to main oscillator
   input wire logic porta6_out_i,  // port bit 6 data in io modes
   input wire logic q1_phase_i,  // core at first quarter phase
   output logic core_reset_o,  // core held in reset
   output logic reset_active_o,  // combined reset to other blocks
   output logic reset_state_load_o,  // force reset-state registers
   output logic clocks_stop_o,  // oscillator and clocks stopped
   output logic osc_out_o,  // oscillator output pin level
   output logic osc_out_oe_n_o,  // oscillator output enable, low drives
   output logic master_clear_oe_n_o,  // master clear pin enable, never drives
   output logic pc_load_o,  // load program counter
   output logic [20:0] pc_value_o,  // program counter value
   output cause_type reset_cause_o,  // last reset cause
   output status_type status_o  // software status flags
);
   seq_state_type state_q, state_d;
   logic [31:0] cnt_q;
   logic [$clog2(master_clear_pin_filter_len+1)-1:0] mf_cnt_q;
   logic master_clear_pin_low_q;
   logic [3:0] por_cnt_q;
   logic supply_q;
   logic pll_pend_q;
   logic wake_q;
   status_type status_q;
   cause_type cause_q;

   wire crystal = (osc_mode_i == low_power_crystal_mode) || (osc_mode_i == standard_crystal_mode)
      || (osc_mode_i == high_speed_crystal_mode) || (osc_mode_i == hs_pll_mode);
   wire is_pll = (osc_mode_i == hs_pll_mode);
   wire io_mode = (osc_mode_i == resistor_cap_io_mode) || (osc_mode_i == external_clock_io_mode);
   wire power_up_delay_timer_on = !powerup_timer_enable_n_i;
   wire bor_hit = brownout_enable_bit_i && brown_out_det_i;
   wire por_pulse = (por_cnt_q != 4'h0);
   wire ost_done = (cnt_q >= 32'(ost_len - 1)) && osc_in_rise_i;
   wire power_up_delay_timer_done = (cnt_q >= 32'(power_up_delay_timer_len - 1)) && rc_tick_i;
   wire pll_done = (cnt_q >= 32'(pll_len - 1));
   wire timing = (state_q == st_por) || (state_q == st_power_up_delay_timer) || (state_q == st_ost)
      || (state_q == st_pll);
   wire int_vector = high_priority_int_enable_i || low_priority_int_enable_i;
   wire sync_reset = reset_instr_i || stack_full_i || stack_underflow_i || watchdog_timeout_i;
   wire wake = int_pending_i || watchdog_timeout_i;
   wire power_up_delay_timer_first = power_up_delay_timer_on ? 1'b1 : 1'b0;
   seq_state_type after_power_up_delay_timer;
   seq_state_type start_state;
   // wake and oscillator switch rerun the counts but must not force registers
   wire wake_set = (state_d == st_ost) && (state_q == st_sleep || state_q == st_run);
   wire wake_d = wake_set || (wake_q && !master_clear_pin_low_q && state_d != st_run && state_d != st_por);

   // first stage after power-up delay; rc or ec skip the start-up count
   assign after_power_up_delay_timer = crystal ? st_ost : st_hold;
   assign start_state = power_up_delay_timer_first ? st_power_up_delay_timer : after_power_up_delay_timer;

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         st_por: if (!por_pulse && supply_q) state_d = start_state;
         st_power_up_delay_timer: if (power_up_delay_timer_done) state_d = after_power_up_delay_timer;
         st_ost: if (ost_done) state_d = (is_pll || pll_pend_q) ? st_pll : st_hold;
         st_pll: if (pll_done) state_d = st_hold;
         st_hold: if (!master_clear_pin_low_q && q1_phase_i) state_d = st_run;
         st_run: if (sleep_instr_i) state_d = st_sleep;
         st_sleep: if (wake) state_d = crystal ? st_ost : st_run;
         default: state_d = st_por;
      endcase
      if (state_q == st_run && osc_switch_i && crystal) state_d = st_ost;
      if (master_clear_pin_low_q && state_q != st_por && state_q != st_power_up_delay_timer && state_q != st_ost
          && state_q != st_pll) state_d = st_hold;
      if (sync_reset && state_q == st_run) state_d = st_hold;
      if (bor_hit) state_d = st_por;
      if (!supply_q) state_d = st_por;
   end

   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_q <= st_por;
         cnt_q <= 32'h0;
      end else begin
         state_q <= state_d;
         if (state_d != state_q) cnt_q <= 32'h0;
         else if ((state_q == st_power_up_delay_timer && rc_tick_i) || (state_q == st_ost && osc_in_rise_i)
                  || state_q == st_pll) cnt_q <= cnt_q + 32'h1;
      end
   end

   // power-on pulse from supply rise, short count stands in for analog pulse
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         supply_q <= 1'b0;
         por_cnt_q <= 4'h0;
      end else begin
         supply_q <= supply_ok_i;
         if (supply_ok_i && !supply_q) por_cnt_q <= 4'(por_pulse_len);
         else if (por_pulse) por_cnt_q <= por_cnt_q - 4'h1;
      end
   end

   // filter: pin must stay at a level for the whole window to be taken
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         mf_cnt_q <= '0;
         master_clear_pin_low_q <= 1'b0;
      end else if ((!master_clear_pin_n_i) == master_clear_pin_low_q) begin
         mf_cnt_q <= '0;
      end else if (mf_cnt_q == ($bits(mf_cnt_q))'(master_clear_pin_filter_len - 1)) begin
         mf_cnt_q <= '0;
         master_clear_pin_low_q <= !master_clear_pin_n_i;
      end else begin
         mf_cnt_q <= mf_cnt_q + ($bits(mf_cnt_q))'(1);
      end
   end

   // pll wake after sleep or switch needs the lock delay too
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pll_pend_q <= 1'b0;
         wake_q <= 1'b0;
      end else begin
         pll_pend_q <= is_pll;
         wake_q <= wake_d;
      end
   end

   // cause and status flags; hardware events only, no software clear here
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         status_q <= status_por;
         cause_q <= cause_power_on;
      end else if (state_q == st_por && por_pulse) begin
         status_q <= status_por;
         cause_q <= cause_power_on;
      end else if (bor_hit) begin
         status_q.reset_instruction_flag <= 1'b1;
         status_q.timeout_flag <= 1'b1;
         status_q.power_down_flag <= 1'b1;
         status_q.power_on_flag <= 1'b1;
         status_q.brown_out_flag <= 1'b0;
         cause_q <= cause_brown_out;
      end else if (state_q == st_sleep && master_clear_pin_low_q) begin
         status_q.timeout_flag <= 1'b1;
         status_q.power_down_flag <= 1'b0;
         cause_q <= cause_master_clear_pin_sleep;
      end else if (state_q == st_sleep && wake) begin
         status_q.timeout_flag <= !watchdog_timeout_i;
         status_q.power_down_flag <= 1'b0;
         cause_q <= watchdog_timeout_i ? cause_wdt_wake : cause_int_wake;
      end else if (state_q == st_run) begin
         if (master_clear_pin_low_q) cause_q <= cause_master_clear_pin_run;
         else if (watchdog_timeout_i) begin
            status_q.reset_instruction_flag <= 1'b1;
            status_q.timeout_flag <= 1'b0;
            status_q.power_down_flag <= 1'b1;
            cause_q <= cause_watchdog;
         end else if (reset_instr_i) begin
            status_q.reset_instruction_flag <= 1'b0;
            cause_q <= cause_reset_instr;
         end else if (stack_full_i) begin
            status_q.stack_full_flag <= 1'b1;
            cause_q <= cause_stack_full;
         end else if (stack_underflow_i) begin
            status_q.stack_underflow_flag <= 1'b1;
            cause_q <= cause_stack_under;
         end
      end
   end

   // outputs all registered
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         core_reset_o <= 1'b1;
         reset_active_o <= 1'b1;
         reset_state_load_o <= 1'b1;
         clocks_stop_o <= 1'b0;
         osc_out_o <= 1'b0;
         osc_out_oe_n_o <= 1'b1;
         master_clear_oe_n_o <= 1'b1;
         pc_load_o <= 1'b0;
         pc_value_o <= pc_reset;
         reset_cause_o <= cause_power_on;
         status_o <= status_por;
      end else begin
         core_reset_o <= (state_d != st_run) && (state_d != st_sleep);
         reset_active_o <= timing || (state_d == st_hold);
         // wake paths leave registers alone; only true resets load them
         reset_state_load_o <= (state_d == st_hold || state_d == st_por) && !wake_d
            && state_q != st_sleep;
         clocks_stop_o <= (state_d == st_sleep);
         osc_out_o <= io_mode ? porta6_out_i : 1'b0;
         osc_out_oe_n_o <= !((state_d == st_sleep) && !crystal) && !io_mode;
         master_clear_oe_n_o <= 1'b1;
         // watchdog wake and unvectored interrupt wake continue in place
         pc_load_o <= (state_q == st_sleep) && (state_d != st_sleep) && !master_clear_pin_low_q
            && int_pending_i && int_vector;
         pc_value_o <= (int_pending_i && int_vector) ? (int_high_i ? pc_vec_high : pc_vec_low)
            : pc_reset;
         reset_cause_o <= cause_q;
         status_o <= status_q;
      end
   end
endmodule : reset_and_startup_sequencer

/* sim/rst_seq_sva.sv */
// port-level assertions for the reset and start-up sequencer
`timescale 1ns/100ps
module rst_seq_sva
   import rst_seq_pkg::*;
(
   input wire logic sys_clk_i,  // clock
   input wire logic rstn_i,  // reset
   input wire logic brown_out_det_i,  // watched
   input wire logic master_clear_pin_n_i,  // watched
   input wire osc_mode_type osc_mode_i,  // watched
   input wire logic brownout_enable_bit_i,  // watched
   input wire logic sleep_instr_i,  // watched
   input wire logic reset_instr_i,  // watched
   input wire logic watchdog_timeout_i,  // watched
   input wire logic int_pending_i,  // watched
   input wire logic core_reset_o,  // watched
   input wire logic reset_active_o,  // watched
   input wire logic reset_state_load_o,  // watched
   input wire logic clocks_stop_o,  // watched
   input wire logic osc_out_o,  // watched
   input wire logic osc_out_oe_n_o,  // watched
   input wire logic pc_load_o,  // watched
   input wire logic master_clear_oe_n_o  // watched
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rstn_i);
   // two cycles stopped, so the registered pin has caught up
   sequence s_halt;
      clocks_stop_o ##1 clocks_stop_o;
   endsequence
   a_clear_never_driven: assert property (master_clear_oe_n_o)
      else $error("master clear pin driven");
   a_brownout_holds: assert property (brownout_enable_bit_i && brown_out_det_i
      |-> ##[1:8] core_reset_o) else $error("brown-out did not reset");
   a_release_needs_pin: assert property ($fell(core_reset_o)
      |-> $past(master_clear_pin_n_i)) else $error("release with clear low");
   a_sleep_stops_clocks: assert property (sleep_instr_i && !core_reset_o
      && !clocks_stop_o |-> ##[1:8] clocks_stop_o) else $error("sleep did not stop clocks");
   a_sleep_pin_low: assert property (s_halt ##0 (osc_mode_i inside
      {resistor_cap_osc_mode, external_clock_mode}) |-> !osc_out_oe_n_o && !osc_out_o)
      else $error("oscillator pin not low in sleep");
   a_active_follows: assert property ($rose(core_reset_o) |-> ##[0:2] reset_active_o)
      else $error("reset active missing");
   a_wdt_wake_keep: assert property (clocks_stop_o && watchdog_timeout_i
      |-> ##1 (!reset_state_load_o)[*4]) else $error("wake forced registers");
   a_instr_loads: assert property (reset_instr_i && !core_reset_o
      |-> ##[1:8] reset_state_load_o) else $error("reset state not forced");
   a_wdt_wake_noload: assert property (clocks_stop_o && watchdog_timeout_i
      && !int_pending_i |-> ##1 !pc_load_o) else $error("watchdog wake loaded the counter");
endmodule : rst_seq_sva
bind reset_and_startup_sequencer rst_seq_sva chk_u (.sys_clk_i, .rstn_i, .brown_out_det_i,
   .master_clear_pin_n_i, .osc_mode_i, .brownout_enable_bit_i, .sleep_instr_i,
   .reset_instr_i, .watchdog_timeout_i, .int_pending_i, .core_reset_o, .reset_active_o,
   .reset_state_load_o, .clocks_stop_o, .osc_out_o, .osc_out_oe_n_o, .pc_load_o,
   .master_clear_oe_n_o);

/* sim/osc_source_model.sv */
// rc oscillator and crystal source model
`timescale 1ns/100ps
module osc_source_model (
   input wire logic sys_clk_i,  // clock
   input wire logic run_i,  // supply up, crystal swinging
   output logic rc_tick_o,  // rc tick every 2 clocks
   output logic osc_rise_o  // crystal rise every 3 clocks
);
   logic [2:0] div_q = 3'h0;
   always_ff @(posedge sys_clk_i) begin
      div_q <= (div_q == 3'h5) ? 3'h0 : div_q + 3'h1;
   end
   assign rc_tick_o = div_q[0];
   // no supply, no crystal edges
   assign osc_rise_o = run_i && (div_q == 3'h0 || div_q == 3'h3);
endmodule : osc_source_model

/* sim/tb_reset_and_startup_sequencer.sv */
// self-checking bench for the reset and start-up sequencer
`timescale 1ns/100ps
module tb_reset_and_startup_sequencer;
   import rst_seq_pkg::*;
   localparam int pw = 20, pl = 10, os = 8;
   logic sys_clk_i = 1'b0, rstn_i = 1'b0, supply_ok_i = 1'b0, brown_out_det_i = 1'b0;
   logic master_clear_pin_n_i = 1'b1, rc_tick_i, osc_in_rise_i, sleep_instr_i = 1'b0;
   logic powerup_timer_enable_n_i = 1'b0, brownout_enable_bit_i = 1'b1, reset_instr_i = 1'b0;
   logic stack_full_i = 1'b0, stack_underflow_i = 1'b0, watchdog_timeout_i = 1'b0;
   logic int_pending_i = 1'b0, high_priority_int_enable_i = 1'b0, int_high_i = 1'b0;
   logic low_priority_int_enable_i = 1'b0, osc_switch_i = 1'b0, porta6_out_i = 1'b0;
   logic q1_phase_i = 1'b1, core_reset_o, reset_active_o, reset_state_load_o, clocks_stop_o;
   logic osc_out_o, osc_out_oe_n_o, master_clear_oe_n_o, pc_load_o;
   logic [20:0] pc_value_o;
   osc_mode_type osc_mode_i = external_clock_mode;
   cause_type reset_cause_o;
   status_type status_o;
   int bad_count = 0, comparisons = 0, n;
   always #2.5 sys_clk_i = ~sys_clk_i;
   osc_source_model osc_u (.sys_clk_i, .run_i(supply_ok_i), .rc_tick_o(rc_tick_i),
      .osc_rise_o(osc_in_rise_i));
   reset_and_startup_sequencer #(.power_up_delay_timer_len(pw), .pll_len(pl), .ost_len(os)) dut_u (
      .sys_clk_i, .rstn_i, .supply_ok_i, .brown_out_det_i, .master_clear_pin_n_i,
      .rc_tick_i, .osc_in_rise_i, .osc_mode_i, .powerup_timer_enable_n_i,
      .brownout_enable_bit_i, .sleep_instr_i, .reset_instr_i, .stack_full_i,
      .stack_underflow_i, .watchdog_timeout_i, .int_pending_i, .high_priority_int_enable_i,
      .low_priority_int_enable_i, .int_high_i, .osc_switch_i, .porta6_out_i, .q1_phase_i,
      .core_reset_o, .reset_active_o, .reset_state_load_o, .clocks_stop_o, .osc_out_o,
      .osc_out_oe_n_o, .master_clear_oe_n_o, .pc_load_o, .pc_value_o, .reset_cause_o,
      .status_o);
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic tick(input int k);
      repeat (k) @(posedge sys_clk_i);
   endtask : tick
   // n counts the cycles spent waiting
   task automatic wait_rst(input logic v);
      n = 0;
      while (core_reset_o !== v && n < 600) begin
         tick(1);
         n++;
      end
   endtask : wait_rst
   task automatic boot(input osc_mode_type m, input logic pe_n);
      rstn_i <= 1'b0;
      supply_ok_i <= 1'b0;
      osc_mode_i <= m;
      powerup_timer_enable_n_i <= pe_n;
      tick(3);
      rstn_i <= 1'b1;
      tick(2);
      supply_ok_i <= 1'b1;
      tick(1);
      wait_rst(1'b0);
   endtask : boot
   task automatic sc_timeouts();
      boot(resistor_cap_osc_mode, 1'b1);
      chk(n < 20, 1);
      boot(standard_crystal_mode, 1'b1);
      chk(n >= 6 + 3 * os && n < 2 * pw, 1);
      boot(hs_pll_mode, 1'b0);
      chk(n >= 5 + 2 * pw + 3 * os + pl, 1);
      boot(external_clock_mode, 1'b0);
      chk(n >= 7 + 2 * pw && n < 2 * pw + 3 * os, 1);
      chk(status_o, status_por);
      chk(reset_cause_o, cause_power_on);
   endtask : sc_timeouts
   task automatic sc_hold();
      master_clear_pin_n_i <= 1'b0;
      boot(external_clock_mode, 1'b0);
      chk(core_reset_o, 1'b1);
      master_clear_pin_n_i <= 1'b1;
      q1_phase_i <= 1'b0;
      tick(10);
      chk(core_reset_o, 1'b1);
      q1_phase_i <= 1'b1;
      wait_rst(1'b0);
      chk(n < 4, 1);
   endtask : sc_hold
   task automatic pulse_clr(input int k);
      master_clear_pin_n_i <= 1'b0;
      tick(k);
      master_clear_pin_n_i <= 1'b1;
      tick(12);
      wait_rst(1'b0);
   endtask : pulse_clr
   task automatic go_sleep(input logic [1:0] pin_exp);
      sleep_instr_i <= 1'b1;
      tick(1);
      sleep_instr_i <= 1'b0;
      tick(8);
      chk(clocks_stop_o, 1'b1);
      chk({osc_out_oe_n_o, osc_out_o}, pin_exp);
   endtask : go_sleep
   task automatic sc_resets();
      cause_type c [4] = '{cause_reset_instr, cause_watchdog, cause_stack_full,
         cause_stack_under};
      pulse_clr(2);
      chk(reset_cause_o, cause_power_on);
      pulse_clr(8);
      chk(reset_cause_o, cause_master_clear_pin_run);
      for (int i = 0; i < 4; i++) begin
         {stack_underflow_i, stack_full_i, watchdog_timeout_i, reset_instr_i} <= 4'h1 << i;
         tick(1);
         {stack_underflow_i, stack_full_i, watchdog_timeout_i, reset_instr_i} <= 4'h0;
         wait_rst(1'b1);
         wait_rst(1'b0);
         chk(reset_cause_o, c[i]);
         if (i < 2) chk({status_o.timeout_flag, status_o.reset_instruction_flag}, 2 - i);
      end
      chk(master_clear_oe_n_o, 1'b1);
   endtask : sc_resets
   task automatic sc_sleep();
      go_sleep(2'b00);
      high_priority_int_enable_i <= 1'b1;
      int_high_i <= 1'b1;
      int_pending_i <= 1'b1;
      n = 0;
      while (pc_load_o !== 1'b1 && n < 50) begin
         tick(1);
         n++;
      end
      chk(pc_load_o, 1'b1);
      chk(pc_value_o, pc_vec_high);
      int_pending_i <= 1'b0;
      tick(4);
      chk({status_o.timeout_flag, status_o.power_down_flag}, 2'b10);
      go_sleep(2'b00);
      watchdog_timeout_i <= 1'b1;
      tick(1);
      watchdog_timeout_i <= 1'b0;
      tick(12);
      chk({core_reset_o, reset_cause_o}, {1'b0, cause_wdt_wake});
      chk({status_o.timeout_flag, status_o.power_down_flag}, 2'b00);
      go_sleep(2'b00);
      pulse_clr(8);
      chk(reset_cause_o, cause_master_clear_pin_sleep);
      chk({status_o.timeout_flag, status_o.power_down_flag}, 2'b10);
   endtask : sc_sleep
   task automatic sc_brown();
      brownout_enable_bit_i <= 1'b0;
      brown_out_det_i <= 1'b1;
      tick(10);
      chk(core_reset_o, 1'b0);
      brownout_enable_bit_i <= 1'b1;
      tick(10);
      chk(core_reset_o, 1'b1);
      brown_out_det_i <= 1'b0;
      tick(20);
      brown_out_det_i <= 1'b1;
      tick(2);
      brown_out_det_i <= 1'b0;
      wait_rst(1'b0);
      chk(n >= 2 * pw - 1, 1);
      chk(reset_cause_o, cause_brown_out);
   endtask : sc_brown
   // wake or switch in pll mode: start-up count plus lock delay, no register load
   task automatic watch_wake();
      int hits = 0;
      n = 0;
      repeat (50) begin
         tick(1);
         if (core_reset_o === 1'b1) n++;
         if (reset_state_load_o !== 1'b0) hits++;
      end
      chk(n >= 3 * os + pl - 3 && n < 3 * os + pl + 4, 1);
      chk(hits, 0);
      chk(core_reset_o, 1'b0);
   endtask : watch_wake
   task automatic sc_wake();
      boot(external_clock_io_mode, 1'b1);
      porta6_out_i <= 1'b1;
      high_priority_int_enable_i <= 1'b0;
      go_sleep(2'b01);
      int_pending_i <= 1'b1;
      n = 0;
      repeat (6) begin
         tick(1);
         if (pc_load_o !== 1'b0) n++;
      end
      int_pending_i <= 1'b0;
      chk(n, 0);
      chk(clocks_stop_o, 1'b0);
      boot(hs_pll_mode, 1'b1);
      go_sleep(2'b10);
      watchdog_timeout_i <= 1'b1;
      tick(1);
      watchdog_timeout_i <= 1'b0;
      watch_wake();
      osc_switch_i <= 1'b1;
      tick(1);
      osc_switch_i <= 1'b0;
      watch_wake();
   endtask : sc_wake
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : end_sim
   initial begin
      tick(20);
      rstn_i <= 1'b1;
      tick(1);
      sc_timeouts();
      sc_hold();
      sc_resets();
      sc_sleep();
      sc_brown();
      sc_wake();
      end_sim();
   end
   // the full run needs roughly 6 us
   initial begin
      #150us;
      bad_count++;
      end_sim();
   end
endmodule : tb_reset_and_startup_sequencer
